/* core/sapp_top.sv */
// Contract
// - Busy goes low at conversion start, stays low until result updated.
// - Byte select low shows upper 8 bits, high shows lower 8 bits.
// - With read_convert_n low, falling select_n starts a conversion.
// - With select_n low and not busy, falling read_convert_n starts conversion.
// - With select_n low, rising read_convert_n enables the result outputs.
// - Result outputs driven only when select_n low and read_convert_n high; here the enable is registered and follows the pins one clock later.
// - Result is 12 bits, bit 11 most significant, bit 0 least.
// - Four zero-fill outputs drive low when outputs enabled, else float.
// - Results are 12-bit two's complement values.
// - A convert command while busy aborts and restarts the converter.
`timescale 1ns/100ps
module sapp_top
  import sapp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic read_convert_n,
  input wire logic byte_select,
  input wire logic [RESULT_W-1:0] sample_code,
  output logic busy_n,
  output logic [RESULT_W-1:0] result_out,
  output logic result_oe,
  output logic [ZFILL_W-1:0] zero_fill_outputs,
  output logic zero_fill_oe
);
  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam int ARM_W = $clog2(START_LOW_CYC + 1);

  // The result must land one cycle before busy rises, so two cycles is the floor.
  if (CONV_CYCLES < 2) begin : g_conv_check
    $error("CONV_CYCLES must be at least 2");
  end

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // Release is synchronised; assertion stays asynchronous.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Edge detection of the combined start condition
  // ---------------------------------------------------------------
  logic sel_d_reg;
  logic rc_d_reg;

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sel_d_reg <= 1'b1;
      rc_d_reg <= 1'b1;
    end else begin
      sel_d_reg <= select_n;
      rc_d_reg <= read_convert_n;
    end
  end

  // The two lines are ORed: start is the combined low level beginning.
  wire both_low = ~select_n & ~read_convert_n;
  wire sel_fall = sel_d_reg & ~select_n;
  wire rc_fall = rc_d_reg & ~read_convert_n;
  wire start_by_sel = sel_fall & ~read_convert_n;
  wire start_by_rc = rc_fall & ~select_n;
  // Falling read_convert_n while busy re-arms regardless of select_n; with select_n high the running conversion resumes.
  wire abort_cmd = rc_fall & ~busy_n;
  wire start_edge = start_by_sel | start_by_rc | abort_cmd;

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  sapp_state_t state_reg;
  sapp_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [ARM_W-1:0] arm_reg;
  logic [ARM_W-1:0] arm_next;
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] result_next;
  logic [RESULT_W-1:0] sample_reg;
  logic [RESULT_W-1:0] sample_next;
  logic busy_n_next;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [ARM_W-1:0] ARM_LAST = ARM_W'(START_LOW_CYC - 1);

  // A start qualifies once the low pulse has lasted the least time; a
  // pulse shorter than that is dropped. A new command during busy
  // aborts the running conversion and begins a fresh one.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    arm_next = arm_reg;
    result_next = result_reg;
    sample_next = sample_reg;
    busy_n_next = busy_n;
    unique case (state_reg)
      SAPP_IDLE: begin
        if (start_edge) begin
          state_next = SAPP_ARM;
          arm_next = '0;
        end
      end
      SAPP_ARM: begin
        if (!(both_low || abort_cmd)) begin
          state_next = busy_n ? SAPP_IDLE : SAPP_CONV;
        end else if (arm_reg >= ARM_LAST) begin
          state_next = SAPP_CONV;
          cnt_next = '0;
          sample_next = sample_code;
          busy_n_next = 1'b0;
        end else begin
          arm_next = arm_reg + ARM_W'(1);
        end
      end
      SAPP_CONV: begin
        if (start_edge) begin
          state_next = SAPP_ARM;
          arm_next = '0;
        end else if (cnt_reg == CNT_LAST) begin
          state_next = SAPP_IDLE;
          busy_n_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_LAST - CNT_W'(1)) begin
            result_next = sample_reg;
          end
        end
      end
      default: begin
        state_next = SAPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= SAPP_IDLE;
      cnt_reg <= '0;
      arm_reg <= '0;
      result_reg <= RESULT_RST;
      sample_reg <= RESULT_RST;
      busy_n <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      arm_reg <= arm_next;
      result_reg <= result_next;
      sample_reg <= sample_next;
      busy_n <= busy_n_next;
    end
  end

  // ---------------------------------------------------------------
  // Output drivers
  // ---------------------------------------------------------------
  sapp_ctrl_t ctrl_bus;
  sapp_bus_t out_bus;

  assign ctrl_bus = '{select_n: select_n, read_convert_n: read_convert_n,
                      byte_select: byte_select};

  sapp_out_drive u_drive (
    .clock(clock),
    .rst_sync_n(rst_sync_reg),
    .ctrl(ctrl_bus),
    .result(result_reg),
    .bus(out_bus)
  );

  // Struct fields are flops inside the driver; these are plain renames, except zero_fill_outputs, tied low here.
  assign result_out = out_bus.data;
  assign result_oe = out_bus.data_oe;
  assign zero_fill_outputs = '0;
  assign zero_fill_oe = out_bus.zfill_oe;
endmodule

/* core/sapp_pkg.sv */
package sapp_pkg;
  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int BYTE_W = 8;
  localparam int ZFILL_W = 4;
  localparam int CLK_PERIOD_PS = 8000;
  // Least time both selects must stay low to start, in nanoseconds.
  localparam int START_LOW_NS = 40;
  localparam int START_LOW_CYC =
    (START_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Modelled conversion length in nanoseconds.
  localparam int CONV_NS = 3200;
  localparam int CONV_CYC = (CONV_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h0000;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    SAPP_IDLE,
    SAPP_ARM,
    SAPP_CONV
  } sapp_state_t;

  // Host-side control pins taken together.
  typedef struct packed {
    logic select_n;
    logic read_convert_n;
    logic byte_select;
  } sapp_ctrl_t;

  // Result bus drive: data, enable, zero-fill enable.
  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic data_oe;
    logic zfill_oe;
  } sapp_bus_t;
endpackage

/* core/sapp_out_drive.sv */
`timescale 1ns/100ps
module sapp_out_drive
  import sapp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_sync_n,
  input wire sapp_ctrl_t ctrl,
  input wire logic [RESULT_W-1:0] result,
  output sapp_bus_t bus
);
  // ---------------------------------------------------------------
  // Output enable decode and byte steering
  // ---------------------------------------------------------------
  // Drive only with select low and read/convert high.
  wire drive_en = ~ctrl.select_n & ctrl.read_convert_n;
  // Low byte select gives bits 11..4 on the byte lanes, high gives 7..0.
  wire [BYTE_W-1:0] upper_byte = result[RESULT_W-1 -: BYTE_W];
  wire [BYTE_W-1:0] lower_byte = result[BYTE_W-1:0];
  // Selected byte on the low eight lines; the four lines above carry bits 11..8 of the word.
  wire [RESULT_W-1:0] word_sel = ctrl.byte_select ?
    {result[RESULT_W-1:BYTE_W], lower_byte} :
    {result[RESULT_W-1:BYTE_W], upper_byte};

  // Registered so every pin comes from a flip-flop; costs one cycle of access.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus <= '0;
    end else begin
      bus.data <= word_sel;
      bus.data_oe <= drive_en;
      bus.zfill_oe <= drive_en;
    end
  end
endmodule

/* verification/sapp_top_props.sv */
`timescale 1ns/100ps
module sapp_top_props
  import sapp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic read_convert_n,
  input wire logic byte_select,
  input wire logic [RESULT_W-1:0] sample_code,
  input wire logic busy_n,
  input wire logic [RESULT_W-1:0] result_out,
  input wire logic result_oe,
  input wire logic [ZFILL_W-1:0] zero_fill_outputs,
  input wire logic zero_fill_oe
);
  // Run lengths of busy low and of both selects low, so long waits need no repetition.
  logic [15:0] busy_run_reg;
  logic [3:0] lo_run_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_run_reg <= 16'h0000;
      lo_run_reg <= 4'h0;
    end else begin
      busy_run_reg <= busy_n ? 16'h0000 : busy_run_reg + 16'h0001;
      lo_run_reg <= (select_n | read_convert_n) ? 4'h0 : lo_run_reg + {3'h0, lo_run_reg != 4'hf};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_busy_len_min: assert property ($rose(busy_n) |-> busy_run_reg >= CONV_CYCLES - 1)
    else $error("busy released too early");
  a_busy_holds: assert property ($fell(busy_n) |=> !busy_n [*6])
    else $error("busy pulse too short");
  a_start_qual: assert property ($fell(busy_n) |-> lo_run_reg >= START_LOW_CYC)
    else $error("conversion began without a long enough low pulse");
  a_out_hiz: assert property (result_oe |-> $past(!select_n && read_convert_n))
    else $error("result driven while not selected for read");
  a_read_enable: assert property ($rose(read_convert_n) && !select_n |=> result_oe)
    else $error("result not driven after read edge");
  a_zfill_oe: assert property (zero_fill_oe == result_oe)
    else $error("zero fill enable differs from result enable");
  a_zfill_low: assert property (zero_fill_oe |-> zero_fill_outputs == 4'h0)
    else $error("zero fill outputs not low");
  a_upper_byte: assert property (result_oe && !$past(byte_select) |-> result_out[7:4] == result_out[11:8])
    else $error("upper byte not on low lanes");
endmodule
bind sapp_top sapp_top_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (.clock(clock), .rst_n(rst_n),
  .select_n(select_n), .read_convert_n(read_convert_n), .byte_select(byte_select),
  .sample_code(sample_code), .busy_n(busy_n), .result_out(result_out), .result_oe(result_oe),
  .zero_fill_outputs(zero_fill_outputs), .zero_fill_oe(zero_fill_oe));

/* verification/sapp_host_model.sv */
`timescale 1ns/100ps
module sapp_host_model
  import sapp_pkg::*;
(
  input wire logic clock,
  output logic select_n,
  output logic read_convert_n,
  output logic byte_select,
  output logic [RESULT_W-1:0] sample_code
);
  // Host idles deselected; all pin changes land 1 ns after a rising edge.
  initial begin
    select_n = 1'b1;
    read_convert_n = 1'b1;
    byte_select = 1'b0;
    sample_code = 12'h000;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pins(input logic s, input logic rc);
    select_n = s;
    read_convert_n = rc;
  endtask
  // A convert is started by either line falling last, then held low for hold cycles.
  task automatic convert(input logic by_cs, input logic [RESULT_W-1:0] code, input int hold);
    sample_code = code;
    if (by_cs) begin
      pins(1'b1, 1'b0);
      step(1);
      select_n = 1'b0;
    end else begin
      pins(1'b0, 1'b1);
      step(1);
      read_convert_n = 1'b0;
    end
    step(hold);
    read_convert_n = 1'b1;
  endtask
  // Two cycles allow for the registered output stage.
  task automatic read(input logic b);
    pins(1'b0, 1'b1);
    byte_select = b;
    step(2);
  endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import sapp_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic select_n, read_convert_n, byte_select, busy_n, result_oe, zero_fill_oe;
  logic [RESULT_W-1:0] sample_code, result_out;
  logic [ZFILL_W-1:0] zero_fill_outputs;
  int err_total = 0;
  int n_checks = 0;
  always #4 clock = ~clock;
  // A short conversion keeps the run brief.
  sapp_top #(.CONV_CYCLES(8)) u_dut (.clock(clock), .rst_n(rst_n), .select_n(select_n),
    .read_convert_n(read_convert_n), .byte_select(byte_select), .sample_code(sample_code),
    .busy_n(busy_n), .result_out(result_out), .result_oe(result_oe),
    .zero_fill_outputs(zero_fill_outputs), .zero_fill_oe(zero_fill_oe));
  sapp_host_model u_host (.clock(clock), .select_n(select_n), .read_convert_n(read_convert_n),
    .byte_select(byte_select), .sample_code(sample_code));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 100 && busy_n !== lvl; i++) u_host.step(1);
    chk("busy_n wait", {11'h000, lvl}, {11'h000, busy_n});
    if (busy_n !== lvl) end_of_test();
  endtask
  task automatic read_word(input logic [11:0] r);
    u_host.read(1'b0);
    chk("upper byte", {r[11:8], r[11:4]}, result_out);
    u_host.read(1'b1);
    chk("lower byte", {r[11:8], r[7:0]}, result_out);
    chk("zero fill", 12'h000, {8'h00, zero_fill_outputs});
  endtask
  task automatic s_convert(input logic by_cs, input logic [11:0] code);
    u_host.convert(by_cs, code, 9);
    wait_busy(1'b0);
    wait_busy(1'b1);
    read_word(code);
  endtask
  task automatic s_short;
    u_host.pins(1'b0, 1'b0);
    u_host.step(2);
    chk("oe in convert", 12'h000, {11'h000, result_oe});
    u_host.pins(1'b0, 1'b1);
    u_host.step(8);
    chk("busy short", 12'h001, {11'h000, busy_n});
  endtask
  task automatic s_hiz;
    u_host.pins(1'b1, 1'b0);
    u_host.step(2);
    chk("oe rc low", 12'h000, {11'h000, result_oe});
    chk("zf oe", 12'h000, {11'h000, zero_fill_oe});
    u_host.pins(1'b1, 1'b1);
    u_host.step(2);
    chk("oe deselect", 12'h000, {11'h000, result_oe});
    u_host.pins(1'b0, 1'b1);
    u_host.step(2);
    chk("oe read", 12'h001, {11'h000, result_oe});
  endtask
  task automatic s_abort;
    u_host.convert(1'b0, 12'h5a5, 9);
    u_host.convert(1'b0, 12'h8c3, 9);
    wait_busy(1'b1);
    read_word(12'h8c3);
  endtask
  // Reset in mid conversion must drop busy and clear the held result.
  task automatic s_reset;
    u_host.convert(1'b0, 12'h3c1, 9);
    rst_n = 1'b0;
    u_host.step(2);
    chk("busy mid reset", 12'h001, {11'h000, busy_n});
    chk("oe mid reset", 12'h000, {11'h000, result_oe});
    rst_n = 1'b1;
    u_host.step(3);
    chk("busy after reset", 12'h001, {11'h000, busy_n});
    read_word(12'h000);
  endtask
  initial begin
    u_host.step(16);
    chk("busy reset", 12'h001, {11'h000, busy_n});
    chk("oe reset", 12'h000, {11'h000, result_oe});
    rst_n = 1'b1;
    u_host.step(3);
    s_convert(1'b0, 12'h7ff);
    s_convert(1'b1, 12'h800);
    s_convert(1'b0, 12'hfff);
    s_short();
    read_word(12'hfff);
    s_hiz();
    s_abort();
    s_reset();
    end_of_test();
  end
endmodule
